// file: rtl/rsf_top.sv
// Contract
// [R1] two buck status bytes at 0x07, 0x08
// [R2] buck fault on retry or enabled-done-not-good
// [R3] retry latches on overcurrent end count, not good
// [R4] retry-mode bit selects channel retry or shutdown
// [R5] negative current limit latches its flag
// [R6] zero-cross latches when enabled in pulse skip
// [R7] latched flags reset zero, clear on read
// [R8] soft start done live: enabled and ramp finished
// [R9] power good shows live comparator
// [R10] enable status shows channel enabled
// [R11] software keeps reserved bits at zero
// [R12] two linear status bytes at 0x09, 0x0A
// [R13] linear fault on enabled-done-not-good only
// [R14] linear current limit bit is live
// [R15] read clears fault only when cause gone
// [R16] unmasked fault pulls interrupt low
// [R17] reserved read zero, writes change nothing
//
// status register bank for buck3, buck4, linear1 and linear2
// assumes: a serial management front end issues one-cycle read and write
// strobes with an 8-bit register offset, all on clk_sys
`timescale 1ns/100ps
`include "rsf_map.svh"

module rsf_top (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// register port
	input  wire logic       rd_en,
	input  wire logic       wr_en,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] wr_data,
	output      logic [7:0] rd_data,
	output      logic       rd_valid,
	// live channel conditions, index 0..3 = buck3, buck4, ldo1, ldo2
	input  wire logic [3:0] enabled,
	input  wire logic [3:0] soft_start_done,
	input  wire logic [3:0] power_good,
	// buck-only conditions, index 0..1 = buck3, buck4
	input  wire logic [1:0] high_side_overcurrent_eoc,
	input  wire logic [1:0] negative_current_limit,
	input  wire logic [1:0] auto_pulse_skip_mode,
	input  wire logic [1:0] zero_cross_trip,
	// linear-only conditions, index 0..1 = ldo1, ldo2
	input  wire logic [1:0] current_limit,
	// channel configuration
	input  wire logic [1:0] retry_mode_enable,
	input  wire logic [3:0] fault_mask,
	// system responses
	output      logic       interrupt_out_n,
	output      logic [1:0] hiccup_restart,
	output      logic       shutdown_all
);

	rsf_pkg::rsf_sel_t  sel;
	logic [3:0]         rd_clr;
	logic [3:0]         fault;
	logic [3:0]         retry_evt;
	rsf_pkg::rsf_byte_t status [`RSF_NUM_CHAN];
	rsf_pkg::rsf_byte_t rd_data_nxt;

	// ------------------------------------------------------------------
	// channels
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RSF_NUM_CHAN; gi++) begin : g_ch
			localparam bit BUCK = (gi < `RSF_NUM_BUCK);
			rsf_chan_if cif ();

			assign cif.enabled    = enabled[gi];
			assign cif.ss_done    = soft_start_done[gi];
			assign cif.power_good = power_good[gi];
			assign cif.rd_clr     = rd_clr[gi];
			if (BUCK) begin : g_buck
				assign cif.overcur_eoc = high_side_overcurrent_eoc[gi];
				assign cif.neg_limit   = negative_current_limit[gi];
				assign cif.zc_enable = auto_pulse_skip_mode[gi];
				assign cif.zc_trip   = zero_cross_trip[gi];
				assign cif.cur_limit = 1'b0;
			end else begin : g_lin
				assign cif.overcur_eoc = 1'b0;
				assign cif.neg_limit   = 1'b0;
				assign cif.zc_enable = 1'b0;
				assign cif.zc_trip   = 1'b0;
				assign cif.cur_limit = current_limit[gi-`RSF_NUM_BUCK];
			end

			assign status[gi]    = cif.status;
			assign fault[gi]     = cif.fault;
			assign retry_evt[gi] = cif.retry_evt;

			rsf_chan #(
				.IS_BUCK (BUCK)
			) u_chan (
				.clk_sys (clk_sys),
				.reset_n (reset_n),
				.ch      (cif.chan)
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	always_comb begin
		case (reg_addr)
			`RSF_OFS_BUCK3_STATUS:   sel = rsf_pkg::RSF_SEL_BUCK3; // R1
			`RSF_OFS_BUCK4_STATUS:   sel = rsf_pkg::RSF_SEL_BUCK4; // R1
			`RSF_OFS_LINEAR1_STATUS: sel = rsf_pkg::RSF_SEL_LINEAR1; // R12
			`RSF_OFS_LINEAR2_STATUS: sel = rsf_pkg::RSF_SEL_LINEAR2; // R12
			default:                 sel = rsf_pkg::RSF_SEL_NONE;
		endcase
	end

	// read clears only the addressed channel; writes never reach a flag
	always_comb begin
		rd_clr      = 4'h0;
		rd_data_nxt = `RSF_UNMAPPED_DATA;
		case (sel)
			rsf_pkg::RSF_SEL_BUCK3: begin
				rd_clr[0]   = rd_en; // R7
				rd_data_nxt = status[0];
			end
			rsf_pkg::RSF_SEL_BUCK4: begin
				rd_clr[1]   = rd_en; // R7
				rd_data_nxt = status[1];
			end
			rsf_pkg::RSF_SEL_LINEAR1: begin
				rd_clr[2]   = rd_en; // R7
				rd_data_nxt = status[2];
			end
			rsf_pkg::RSF_SEL_LINEAR2: begin
				rd_clr[3]   = rd_en; // R7
				rd_data_nxt = status[3];
			end
			default: begin
				rd_clr      = 4'h0; // R17
				rd_data_nxt = `RSF_UNMAPPED_DATA;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	// the byte captured is the one before the read's own clear
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_data  <= `RSF_STATUS_RST;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= rd_data_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			interrupt_out_n <= 1'b1;
		end else begin
			interrupt_out_n <= ~|(fault & ~fault_mask); // R16
		end
	end

	// ------------------------------------------------------------------
	// retry response
	// ------------------------------------------------------------------
	// retry mode restarts only the channel, otherwise everything stops
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hiccup_restart <= 2'h0;
			shutdown_all   <= 1'b0;
		end else begin
			hiccup_restart <= retry_evt[1:0] & retry_mode_enable; // R4
			shutdown_all   <= |(retry_evt[1:0] & ~retry_mode_enable); // R4
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_rd_answer: assert property (@(posedge clk_sys) // R1 R12
		disable iff (!reset_n)
		rd_en |=> rd_valid ##1 (rd_valid == $past(rd_en)))
		else $error("read answer not one cycle later");
	a_rd_unmapped: assert property (@(posedge clk_sys) // R17
		disable iff (!reset_n)
		rd_en && sel == rsf_pkg::RSF_SEL_NONE |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_buck_resv: assert property (@(posedge clk_sys) // R17
		disable iff (!reset_n)
		rd_en && reg_addr == `RSF_OFS_BUCK4_STATUS
		|=> !rd_data[`RSF_BIT_CUR_LIMIT])
		else $error("buck reserved bit read as one");
	a_lin_resv: assert property (@(posedge clk_sys) // R17
		disable iff (!reset_n)
		rd_en && reg_addr == `RSF_OFS_LINEAR1_STATUS
		|=> rd_data[6:4] == 3'h0)
		else $error("linear reserved bits read as one");
	a_live_bits: assert property (@(posedge clk_sys) // R8
		disable iff (!reset_n)
		rd_en && reg_addr == `RSF_OFS_BUCK3_STATUS |=>
		rd_data[2:0] == {$past(enabled[0]) & $past(soft_start_done[0]),
			$past(power_good[0]), $past(enabled[0])})
		else $error("live bits wrong on buck3 read");
	a_lin_limit: assert property (@(posedge clk_sys) // R14
		disable iff (!reset_n)
		rd_en && reg_addr == `RSF_OFS_LINEAR2_STATUS
		|=> rd_data[`RSF_BIT_CUR_LIMIT] == $past(current_limit[1]))
		else $error("linear current limit bit wrong");
	a_irq_assert: assert property (@(posedge clk_sys) // R16
		disable iff (!reset_n)
		|(fault & ~fault_mask) |=> !interrupt_out_n)
		else $error("unmasked fault left interrupt high");
	a_irq_masked: assert property (@(posedge clk_sys) // R16
		disable iff (!reset_n)
		(fault & ~fault_mask) == 4'h0 |=> interrupt_out_n)
		else $error("interrupt low with no unmasked fault");
	a_retry_shut: assert property (@(posedge clk_sys) // R4
		disable iff (!reset_n)
		retry_evt[0] && !retry_mode_enable[0]
		|=> shutdown_all && !hiccup_restart[0])
		else $error("retry without retry mode did not shut down");
	a_write_inert: assert property (@(posedge clk_sys) // R17
		disable iff (!reset_n)
		wr_en && !rd_en |-> rd_clr == 4'h0 ##1 $stable(rd_data))
		else $error("write cleared a flag or moved read data");

endmodule // rsf_top

// file: rtl/rsf_map.svh
// register offsets, field positions and reset values of the status bank
// assumes: included by the bare name wherever a number is needed
`ifndef RSF_MAP_SVH
`define RSF_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RSF_OFS_BUCK3_STATUS    8'h07
`define RSF_OFS_BUCK4_STATUS    8'h08
`define RSF_OFS_LINEAR1_STATUS  8'h09
`define RSF_OFS_LINEAR2_STATUS  8'h0A

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RSF_BIT_FAULT           7
`define RSF_BIT_RETRY           6
`define RSF_BIT_NEG_LIMIT       5
`define RSF_BIT_ZERO_CROSS      4
`define RSF_BIT_CUR_LIMIT       3
`define RSF_BIT_SS_DONE         2
`define RSF_BIT_POWER_GOOD      1
`define RSF_BIT_ENABLE          0

// ----------------------------------------------------------------------
// reset and fill values, channel counts
// ----------------------------------------------------------------------
`define RSF_STATUS_RST          8'h00
`define RSF_UNMAPPED_DATA       8'h00
`define RSF_NUM_CHAN            4
`define RSF_NUM_BUCK            2

`endif

// file: rtl/rsf_pkg.sv
// types shared by the status bank modules
// assumes: rsf_map.svh is on the include path
package rsf_pkg;

	typedef logic [7:0] rsf_byte_t;

	// which status register an address selects
	typedef enum {
		RSF_SEL_BUCK3,
		RSF_SEL_BUCK4,
		RSF_SEL_LINEAR1,
		RSF_SEL_LINEAR2,
		RSF_SEL_NONE
	} rsf_sel_t;

endpackage

// file: rtl/rsf_chan_if.sv
// bundle between the bank top and one channel's flag logic
// assumes: one instance per channel, same clock as the top
`timescale 1ns/100ps

interface rsf_chan_if;
	// live conditions from the analog side
	logic              enabled;
	logic              ss_done;
	logic              power_good;
	logic              overcur_eoc;
	logic              neg_limit;
	logic              zc_enable;
	logic              zc_trip;
	logic              cur_limit;
	// read side effect
	logic              rd_clr;
	// results
	rsf_pkg::rsf_byte_t status;
	logic              fault;
	logic              retry_evt;

	modport chan (
		input  enabled, ss_done, power_good, overcur_eoc, neg_limit,
		input  zc_enable, zc_trip, cur_limit, rd_clr,
		output status, fault, retry_evt
	);
	modport top (
		output enabled, ss_done, power_good, overcur_eoc, neg_limit,
		output zc_enable, zc_trip, cur_limit, rd_clr,
		input  status, fault, retry_evt
	);
endinterface

// file: rtl/rsf_chan.sv
// latched and live status bits of one regulator channel
// assumes: inputs synchronous to clk_sys; rd_clr is a one-cycle pulse
`timescale 1ns/100ps
`include "rsf_map.svh"

module rsf_chan #(
	parameter bit IS_BUCK = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// channel bundle
	rsf_chan_if.chan ch
);

	logic fault_r;
	logic retry_r;
	logic neg_r;
	logic zc_r;
	logic retry_set;
	logic live_fault;
	logic neg_set;
	logic zc_set;

	// ------------------------------------------------------------------
	// set conditions
	// ------------------------------------------------------------------
	assign retry_set  = IS_BUCK & ch.overcur_eoc & ~ch.power_good; // R3
	assign live_fault = ch.enabled & ch.ss_done & ~ch.power_good; // R2 R13
	assign neg_set    = IS_BUCK & ch.neg_limit; // R5
	assign zc_set     = IS_BUCK & ch.zc_enable & ch.zc_trip; // R6

	// ------------------------------------------------------------------
	// latched flags: set wins over the read clear
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fault_r <= 1'b0; // R7
		end else begin
			// clears on read only once the condition is gone
			fault_r <= retry_set | live_fault | (retry_r & ~ch.rd_clr)
				| (fault_r & ~ch.rd_clr); // R2 R15
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			retry_r <= 1'b0;
			neg_r   <= 1'b0;
			zc_r    <= 1'b0;
		end else begin
			retry_r <= retry_set | (retry_r & ~ch.rd_clr); // R3 R7
			neg_r   <= neg_set | (neg_r & ~ch.rd_clr); // R5 R7
			zc_r    <= zc_set | (zc_r & ~ch.rd_clr); // R6 R7
		end
	end

	// ------------------------------------------------------------------
	// status byte, reserved bits held at zero
	// ------------------------------------------------------------------
	always_comb begin
		ch.status = `RSF_STATUS_RST; // R17
		ch.status[`RSF_BIT_FAULT]      = fault_r;
		ch.status[`RSF_BIT_SS_DONE]    = ch.enabled & ch.ss_done; // R8
		ch.status[`RSF_BIT_POWER_GOOD] = ch.power_good; // R9
		ch.status[`RSF_BIT_ENABLE]     = ch.enabled; // R10
		if (IS_BUCK) begin
			ch.status[`RSF_BIT_RETRY]      = retry_r;
			ch.status[`RSF_BIT_NEG_LIMIT]  = neg_r;
			ch.status[`RSF_BIT_ZERO_CROSS] = zc_r;
		end else begin
			ch.status[`RSF_BIT_CUR_LIMIT]  = ch.cur_limit; // R14
		end
	end

	assign ch.fault     = fault_r;
	assign ch.retry_evt = retry_set & ~retry_r;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_fault_live_set: assert property ( // R2
		live_fault |=> fault_r ##0 ch.status[`RSF_BIT_FAULT])
		else $error("fault flag missed a live fault");
	a_retry_latch: assert property ( // R3
		retry_set |=> retry_r [*1] ##1 (retry_r || $past(ch.rd_clr)))
		else $error("retry flag not latched");
	a_retry_fault: assert property ( // R2
		retry_set |=> fault_r)
		else $error("retry did not set fault");
	a_neg_latch: assert property ( // R5
		neg_set |=> neg_r)
		else $error("negative limit flag not latched");
	a_zc_latch: assert property ( // R6
		zc_set |=> zc_r)
		else $error("zero cross flag not latched");
	a_read_clears: assert property ( // R7
		ch.rd_clr && !neg_set && !zc_set |=> !neg_r && !zc_r)
		else $error("read did not clear latched flags");
	a_fault_sticky: assert property ( // R15
		fault_r && !ch.rd_clr |=> fault_r)
		else $error("fault dropped without a read");
	a_fault_cleared: assert property ( // R15
		ch.rd_clr && !live_fault && !retry_set |=> !fault_r)
		else $error("fault survived a read with no cause");

endmodule // rsf_chan

// file: tb/tb_regulator_status_flags.sv
// self-checking bench for the status register bank, random and corner cases
// assumes: rsf_map.svh on the include path; rsf_top compiled before this file
`timescale 1ns/100ps
`include "rsf_map.svh"

`define RSF_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	bad_count++; $display("mismatch %s expected %h seen %h", nm, e, g); \
	end end

module tb_regulator_status_flags;

	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic       clk_sys, reset_n, rd_en, wr_en, rd_valid, interrupt_out_n;
	logic       shutdown_all;
	logic [7:0] reg_addr, wr_data, rd_data;
	logic [3:0] enabled, soft_start_done, power_good, fault_mask;
	logic [1:0] high_side_overcurrent_eoc, negative_current_limit;
	logic [1:0] auto_pulse_skip_mode, zero_cross_trip, current_limit;
	logic [1:0] retry_mode_enable, hiccup_restart;
	int         bad_count = 0;
	int         comparisons = 0;
	// bench copy of the latched flags
	logic [3:0] fau;
	logic [1:0] rty, ngf, zcf;
	logic [7:0] last_data;

	rsf_top u_dut (
		.clk_sys                   (clk_sys),
		.reset_n                   (reset_n),
		.rd_en                     (rd_en),
		.wr_en                     (wr_en),
		.reg_addr                  (reg_addr),
		.wr_data                   (wr_data),
		.rd_data                   (rd_data),
		.rd_valid                  (rd_valid),
		.enabled                   (enabled),
		.soft_start_done           (soft_start_done),
		.power_good                (power_good),
		.high_side_overcurrent_eoc (high_side_overcurrent_eoc),
		.negative_current_limit    (negative_current_limit),
		.auto_pulse_skip_mode      (auto_pulse_skip_mode),
		.zero_cross_trip           (zero_cross_trip),
		.current_limit             (current_limit),
		.retry_mode_enable         (retry_mode_enable),
		.fault_mask                (fault_mask),
		.interrupt_out_n           (interrupt_out_n),
		.hiccup_restart            (hiccup_restart),
		.shutdown_all              (shutdown_all)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// ------------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------------
	function automatic logic [7:0] chan_status(input int c);
		logic [2:0] live;
		live = {enabled[c] & soft_start_done[c], power_good[c], enabled[c]};
		if (c < 2)
			return {fau[c], rty[c], ngf[c], zcf[c], 1'b0, live};
		return {fau[c], 3'h0, current_limit[c-2], live};
	endfunction

	function automatic int addr_chan(input logic [7:0] a);
		case (a)
			`RSF_OFS_BUCK3_STATUS:   return 0;
			`RSF_OFS_BUCK4_STATUS:   return 1;
			`RSF_OFS_LINEAR1_STATUS: return 2;
			`RSF_OFS_LINEAR2_STATUS: return 3;
			default:                 return -1;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// cycle model and output comparison
	// ------------------------------------------------------------------
	always @(posedge clk_sys) begin : model
		logic [7:0] e_data;
		logic       e_valid, e_int, e_sd, clr, live, rc;
		logic [1:0] e_hic;
		int         sel;
		e_hic = 2'h0;
		e_sd = 1'b0;
		e_int = 1'b1;
		if (!reset_n) begin
			fau = 4'h0;
			rty = 2'h0;
			ngf = 2'h0;
			zcf = 2'h0;
			e_valid = 1'b0;
			e_data = 8'h00;
		end else begin
			sel = addr_chan(reg_addr);
			e_valid = rd_en;
			e_data = last_data;
			if (rd_en)
				e_data = (sel < 0) ? 8'h00 : chan_status(sel);
			for (int c = 0; c < 4; c++) begin
				if (fau[c] && !fault_mask[c])
					e_int = 1'b0;
				clr = rd_en && (sel == c);
				live = enabled[c] & soft_start_done[c] & ~power_good[c];
				if (c < 2) begin
					rc = high_side_overcurrent_eoc[c] & ~power_good[c];
					if (rc && !rty[c]) begin
						if (retry_mode_enable[c])
							e_hic[c] = 1'b1;
						else
							e_sd = 1'b1;
					end
					fau[c] = rc | live | ((fau[c] | rty[c]) & ~clr);
					rty[c] = rc | (rty[c] & ~clr);
					ngf[c] = negative_current_limit[c] | (ngf[c] & ~clr);
					zcf[c] = (auto_pulse_skip_mode[c] & zero_cross_trip[c]) |
						(zcf[c] & ~clr);
				end else begin
					fau[c] = live | (fau[c] & ~clr);
				end
			end
		end
		last_data = e_data;
		#1;
		`RSF_CHK("rd_valid", e_valid, rd_valid)
		`RSF_CHK("rd_flags", e_data[7:4], rd_data[7:4])
		`RSF_CHK("rd_fault", e_data[7], rd_data[7])
		`RSF_CHK("rd_data", e_data, rd_data)
		`RSF_CHK("interrupt_out_n", e_int, interrupt_out_n)
		`RSF_CHK("hiccup_restart", e_hic, hiccup_restart)
		`RSF_CHK("shutdown_all", e_sd, shutdown_all)
	end

	// ------------------------------------------------------------------
	// drivers, all at the falling edge
	// ------------------------------------------------------------------
	task automatic set_in(input logic [3:0] en, ss, pg, mk,
		input logic [1:0] eoc, ng, ap, zt, il, md);
		@(negedge clk_sys);
		{enabled, soft_start_done, power_good, fault_mask} = {en, ss, pg, mk};
		{high_side_overcurrent_eoc, negative_current_limit} = {eoc, ng};
		{auto_pulse_skip_mode, zero_cross_trip} = {ap, zt};
		{current_limit, retry_mode_enable} = {il, md};
		rd_en = 1'b0;
		wr_en = 1'b0;
	endtask

	task automatic acc(input logic rd, wr, input logic [7:0] a, d);
		@(negedge clk_sys);
		rd_en = rd;
		wr_en = wr;
		reg_addr = a;
		wr_data = d;
	endtask

	task automatic read_all();
		for (int a = 7; a < 11; a++)
			acc(1'b1, 1'b0, 8'(a), 8'h00);
		acc(1'b0, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic conclude();
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#1000000;
		bad_count++;
		conclude();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		{rd_en, wr_en, reg_addr, wr_data} = '0;
		{enabled, soft_start_done, power_good, fault_mask} = '0;
		{high_side_overcurrent_eoc, negative_current_limit} = '0;
		{auto_pulse_skip_mode, zero_cross_trip, current_limit} = '0;
		retry_mode_enable = 2'h0;
		void'($urandom(70));
		repeat (10) @(negedge clk_sys);
		reset_n = 1'b1;
		// offsets 0 to 15 and 0xFF, unmapped ones included
		for (int a = 0; a < 16; a++)
			acc(1'b1, 1'b0, 8'(a), 8'h00);
		acc(1'b1, 1'b0, 8'hFF, 8'h00);
		// faults everywhere, unmasked, then writes that must not clear
		set_in(4'hF, 4'hF, 4'h0, 4'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0);
		set_in(4'hF, 4'hF, 4'hF, 4'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		for (int a = 7; a < 11; a++)
			acc(1'b0, 1'b1, 8'(a), 8'h87);
		read_all();
		read_all();
		// fault cause still present across back-to-back reads
		set_in(4'hF, 4'hF, 4'h0, 4'h5, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0);
		read_all();
		acc(1'b1, 1'b1, 8'h09, 8'h87);
		acc(1'b1, 1'b0, 8'h09, 8'h00);
		set_in(4'hF, 4'hF, 4'hF, 4'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0);
		read_all();
		read_all();
		// retry in both response modes, held then re-armed by a read
		for (int m = 0; m < 4; m++) begin
			set_in(4'h3, 4'h0, 4'h0, 4'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'(m));
			set_in(4'h3, 4'h0, 4'h0, 4'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'(m));
			read_all();
			set_in(4'h3, 4'h3, 4'hF, 4'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'(m));
			read_all();
			read_all();
		end
		// random traffic, inputs held steady across each read edge
		repeat (3000) begin
			set_in(4'($urandom), 4'($urandom), 4'($urandom | $urandom),
				4'($urandom), ($urandom % 6 == 0) ? 2'($urandom) : 2'h0,
				($urandom % 4 == 0) ? 2'($urandom) : 2'h0, 2'($urandom),
				2'($urandom), 2'($urandom), 2'($urandom));
			acc(1'($urandom), 1'($urandom), ($urandom % 4 == 0) ?
				8'($urandom) : 8'(7 + $urandom % 4), 8'($urandom) & 8'h87);
			if ($urandom % 3 == 0)
				acc(1'b1, 1'b0, 8'(7 + $urandom % 4), 8'h00);
		end
		// second reset in mid-run with flags standing
		set_in(4'hF, 4'hF, 4'h0, 4'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1);
		@(negedge clk_sys);
		reset_n = 1'b0;
		set_in(4'h0, 4'h0, 4'hF, 4'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0);
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		read_all();
		repeat (3) @(negedge clk_sys);
		conclude();
	end

endmodule // tb_regulator_status_flags
